/* verilog/rtc_core.sv */
// Time, calendar and alarm core with a byte-addressed host port
`timescale 1ns/100ps
`default_nettype none
module rtc_core #(
  parameter int unsigned REC_MS = rtc_pkg::REC_MS_DEFAULT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Timebase, one pulse per 32.768 kHz period
  input wire logic osc_tick,
  // Supply monitor
  input wire logic supply_ok,
  input wire logic battery_ok,
  // Multiplexed host bus
  input wire logic host_cs,
  input wire logic host_ale,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_ad_in,
  output logic [7:0] host_ad_out,
  output logic host_ad_oe,
  // Open-drain interrupt request, low when active
  output logic irq_n_out,
  output logic irq_n_oe,
  // Status
  output logic host_access_ok
);
  import rtc_pkg::*;

  localparam int unsigned REC_CYCLES = REC_MS * CYCLES_PER_MS;
  localparam int unsigned REC_W = $clog2(REC_CYCLES + 1);
  localparam logic [REC_W-1:0] REC_LOAD = REC_W'(REC_CYCLES);

  logic [7:0] mem_q [0:MEM_BYTES-1];
  logic [6:0] reg_a_q;
  logic [7:0] reg_b_q;
  logic af_q;
  logic uf_q;
  logic [DIV_W-1:0] div_q;
  logic upd_q;
  logic supply_q;
  logic [REC_W-1:0] rec_cnt_q;
  logic [6:0] addr_q;
  logic rd_q;
  logic wr_q;
  logic [7:0] ad_out_q;

  logic osc_run;
  logic osc_stopped;
  logic sec_pulse;
  logic upd_go;
  logic update_pending_flag;
  logic supply_rise;
  logic access_ok;
  logic rd_go;
  logic wr_go;
  logic ctrl_addr;
  logic irq_req;
  logic alarm_hit;
  logic [7:0] rd_data;
  logic [7:0] nxt_sec, nxt_min, nxt_hour, nxt_dow;
  logic [7:0] nxt_date, nxt_mon, nxt_year, nxt_cent;

  // Oscillator field decode
  assign osc_run = (reg_a_q[A_OSC_HI:A_OSC_LO] == OSC_RUN);
  assign osc_stopped = !osc_run &&
                       (reg_a_q[A_OSC_HI:A_OSC_LO+1] != OSC_HOLD);

  // Divider chain; a held chain restarts half a second before rollover
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_q <= DIV_RELOAD;
    end else if (!osc_run) begin
      div_q <= DIV_RELOAD;
    end else if (osc_tick) begin
      div_q <= div_q + 1'b1;
    end
  end

  assign sec_pulse = osc_run && osc_tick && (div_q == DIV_LAST);
  assign upd_go = sec_pulse && !reg_b_q[B_SET];
  assign update_pending_flag = osc_run && !reg_b_q[B_SET] && (div_q >= UIP_START);

  // Alarm check one cycle after the advance
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      upd_q <= 1'b0;
    end else begin
      upd_q <= upd_go;
    end
  end

  rtc_time_step u_step (
    .dm(reg_b_q[B_DM]),
    .h24(reg_b_q[B_24H]),
    .cur_sec(mem_q[ADDR_SEC]),
    .cur_min(mem_q[ADDR_MIN]),
    .cur_hour(mem_q[ADDR_HOUR]),
    .cur_dow(mem_q[ADDR_DOW]),
    .cur_date(mem_q[ADDR_DATE]),
    .cur_mon(mem_q[ADDR_MON]),
    .cur_year(mem_q[ADDR_YEAR]),
    .cur_cent(mem_q[ADDR_CENT]),
    .nxt_sec(nxt_sec),
    .nxt_min(nxt_min),
    .nxt_hour(nxt_hour),
    .nxt_dow(nxt_dow),
    .nxt_date(nxt_date),
    .nxt_mon(nxt_mon),
    .nxt_year(nxt_year),
    .nxt_cent(nxt_cent)
  );

  rtc_alarm_match u_alarm (
    .cur_sec(mem_q[ADDR_SEC]),
    .cur_min(mem_q[ADDR_MIN]),
    .cur_hour(mem_q[ADDR_HOUR]),
    .alm_sec(mem_q[ADDR_ASEC]),
    .alm_min(mem_q[ADDR_AMIN]),
    .alm_hour(mem_q[ADDR_AHOUR]),
    .match(alarm_hit)
  );

  // Power-up lockout
  assign supply_rise = supply_ok && !supply_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      supply_q <= 1'b0;
      rec_cnt_q <= '0;
    end else begin
      supply_q <= supply_ok;
      if (!supply_ok) begin
        rec_cnt_q <= '0;
      end else if (supply_rise && osc_run) begin
        rec_cnt_q <= REC_LOAD;
      end else if (rec_cnt_q != '0) begin
        rec_cnt_q <= rec_cnt_q - 1'b1;
      end
    end
  end

  // A stopped oscillator skips the count
  assign access_ok = supply_ok && supply_q && (rec_cnt_q == '0);
  assign host_access_ok = access_ok;

  // Bus strobes act on their first cycle only
  assign rd_go = host_cs && host_rd && !rd_q && access_ok;
  assign wr_go = host_cs && host_wr && !wr_q && access_ok;
  assign ctrl_addr = (addr_q >= ADDR_A) && (addr_q <= ADDR_D);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      addr_q <= ADDR_SEC;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      ad_out_q <= BYTE_RST;
    end else begin
      rd_q <= host_cs && host_rd;
      wr_q <= host_cs && host_wr;
      if (host_cs && host_ale && access_ok) begin
        addr_q <= host_ad_in[6:0];
      end
      if (rd_go) begin
        ad_out_q <= rd_data;
      end
    end
  end

  assign host_ad_out = ad_out_q;
  assign host_ad_oe = host_cs && host_rd && access_ok;

  // Read view; readable in every cycle with host access open, even mid-update
  always_comb begin
    case (addr_q)
      ADDR_A: rd_data = {update_pending_flag, reg_a_q};
      ADDR_B: rd_data = reg_b_q;
      ADDR_C: rd_data = {irq_req, 1'b0, af_q, uf_q, 4'h0};
      ADDR_D: rd_data = {battery_ok, 7'h00};
      default: rd_data = mem_q[addr_q];
    endcase
  end

  // Control bytes; flag bit of A is computed, never stored
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_a_q <= REG_A_RST;
      reg_b_q <= REG_B_RST;
    end else begin
      if (wr_go && addr_q == ADDR_A) begin
        reg_a_q <= host_ad_in[6:0];
      end
      if (wr_go && addr_q == ADDR_B) begin
        reg_b_q <= host_ad_in;
        // Raising the hold bit drops the update-ended enable
        if (host_ad_in[B_SET] && !reg_b_q[B_SET]) begin
          reg_b_q[B_UIE] <= 1'b0;
        end
      end
      if (supply_rise && osc_stopped) begin
        reg_a_q[A_OSC_HI:A_OSC_LO] <= OSC_RUN;
      end
    end
  end

  // Status flags: reading C clears them, a new event wins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      af_q <= 1'b0;
      uf_q <= 1'b0;
    end else begin
      if (rd_go && addr_q == ADDR_C) begin
        af_q <= 1'b0;
        uf_q <= 1'b0;
      end
      if (upd_q) begin
        uf_q <= 1'b1;
      end
      if (upd_q && alarm_hit) begin
        af_q <= 1'b1;
      end
    end
  end

  assign irq_req = (af_q && reg_b_q[B_AIE]) ||
                   (uf_q && reg_b_q[B_UIE]);
  assign irq_n_out = 1'b0;
  assign irq_n_oe = irq_req;

  // Byte store: clock bytes, century and general storage
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem_q[i] <= BYTE_RST;
      end
      mem_q[ADDR_DOW] <= CAL_RST;
      mem_q[ADDR_DATE] <= CAL_RST;
      mem_q[ADDR_MON] <= CAL_RST;
    end else begin
      // Whole-second advance lands in one cycle
      if (upd_go) begin
        mem_q[ADDR_SEC] <= nxt_sec;
        mem_q[ADDR_MIN] <= nxt_min;
        mem_q[ADDR_HOUR] <= nxt_hour;
        mem_q[ADDR_DOW] <= nxt_dow;
        mem_q[ADDR_DATE] <= nxt_date;
        mem_q[ADDR_MON] <= nxt_mon;
        mem_q[ADDR_YEAR] <= nxt_year;
        mem_q[ADDR_CENT] <= nxt_cent;
      end
      // A host write in the same cycle overrides the advance
      if (wr_go && !ctrl_addr) begin
        if (addr_q == ADDR_SEC) begin
          mem_q[addr_q] <= {1'b0, host_ad_in[6:0]};
        end else begin
          mem_q[addr_q] <= host_ad_in;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* verilog/rtc_pkg.sv */
// Shared constants and format helpers for the real-time clock core
package rtc_pkg;

  // Clock rates and derived counts
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned OSC_HZ = 32_768;
  localparam int unsigned DIV_W = $clog2(OSC_HZ);
  localparam int unsigned UIP_LEAD_US = 244;
  localparam int unsigned UIP_LEAD_TICKS =
    (UIP_LEAD_US * OSC_HZ + 999_999) / 1_000_000;
  localparam int unsigned REC_MS_DEFAULT = 200;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1_000;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_HZ - 1);
  localparam logic [DIV_W-1:0] DIV_RELOAD = DIV_W'(OSC_HZ / 2);
  localparam logic [DIV_W-1:0] UIP_START = DIV_W'(OSC_HZ - UIP_LEAD_TICKS);

  // Byte map
  localparam int unsigned MEM_BYTES = 128;
  localparam logic [6:0] ADDR_SEC = 7'h00;
  localparam logic [6:0] ADDR_ASEC = 7'h01;
  localparam logic [6:0] ADDR_MIN = 7'h02;
  localparam logic [6:0] ADDR_AMIN = 7'h03;
  localparam logic [6:0] ADDR_HOUR = 7'h04;
  localparam logic [6:0] ADDR_AHOUR = 7'h05;
  localparam logic [6:0] ADDR_DOW = 7'h06;
  localparam logic [6:0] ADDR_DATE = 7'h07;
  localparam logic [6:0] ADDR_MON = 7'h08;
  localparam logic [6:0] ADDR_YEAR = 7'h09;
  localparam logic [6:0] ADDR_A = 7'h0A;
  localparam logic [6:0] ADDR_B = 7'h0B;
  localparam logic [6:0] ADDR_C = 7'h0C;
  localparam logic [6:0] ADDR_D = 7'h0D;
  localparam logic [6:0] ADDR_CENT = 7'h32;

  // Field positions
  localparam int unsigned A_OSC_HI = 6;
  localparam int unsigned A_OSC_LO = 4;
  localparam logic [2:0] OSC_RUN = 3'b010;
  localparam logic [1:0] OSC_HOLD = 2'b11;
  localparam int unsigned B_SET = 7;
  localparam int unsigned B_PIE = 6;
  localparam int unsigned B_AIE = 5;
  localparam int unsigned B_UIE = 4;
  localparam int unsigned B_SQWE = 3;
  localparam int unsigned B_DM = 2;
  localparam int unsigned B_24H = 1;
  localparam logic [1:0] DONT_CARE = 2'b11;

  // Values after reset
  localparam logic [6:0] REG_A_RST = 7'h00;
  localparam logic [7:0] REG_B_RST = 8'h02;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] CAL_RST = 8'h01;

  // Counter limits, binary
  localparam logic [7:0] MAX_SEC = 8'h3B;
  localparam logic [7:0] MAX_HOUR24 = 8'h17;
  localparam logic [7:0] HOUR12_LAST_AM = 8'h0B;
  localparam logic [7:0] HOUR12_TOP = 8'h0C;
  localparam logic [7:0] MAX_DOW = 8'h07;
  localparam logic [7:0] MAX_MON = 8'h0C;
  localparam logic [7:0] MAX_YEAR = 8'h63;
  localparam logic [7:0] DAYS_31 = 8'h1F;
  localparam logic [7:0] DAYS_30 = 8'h1E;
  localparam logic [7:0] DAYS_29 = 8'h1D;
  localparam logic [7:0] DAYS_28 = 8'h1C;
  localparam logic [7:0] TEN = 8'h0A;

  // Stored byte to binary; format bit low means BCD
  function automatic logic [7:0] to_bin(input logic [7:0] v,
                                        input logic dm);
    return dm ? v : ({4'h0, v[7:4]} * TEN) + {4'h0, v[3:0]};
  endfunction

  // Binary to stored byte in the selected format
  function automatic logic [7:0] to_enc(input logic [7:0] b,
                                        input logic dm);
    logic [7:0] tens;
    logic [7:0] ones;
    tens = b / TEN;
    ones = b % TEN;
    return dm ? b : {tens[3:0], ones[3:0]};
  endfunction

endpackage

/* verilog/rtc_alarm_match.sv */
// Alarm comparison of hours, minutes and seconds with don't-care codes
`timescale 1ns/100ps
`default_nettype none
module rtc_alarm_match (
  // Current time
  input wire logic [7:0] cur_sec,
  input wire logic [7:0] cur_min,
  input wire logic [7:0] cur_hour,
  // Alarm bytes
  input wire logic [7:0] alm_sec,
  input wire logic [7:0] alm_min,
  input wire logic [7:0] alm_hour,
  // Result
  output logic match
);
  import rtc_pkg::*;

  logic [2:0][7:0] time_bytes;
  logic [2:0][7:0] alarm_bytes;
  logic [2:0] hit;

  assign time_bytes = {cur_hour, cur_min, cur_sec};
  assign alarm_bytes = {alm_hour, alm_min, alm_sec};

  for (genvar i = 0; i < 3; i++) begin : g_byte
    // Top two bits set means any value matches
    assign hit[i] = (alarm_bytes[i][7:6] == DONT_CARE) ||
                    (alarm_bytes[i] == time_bytes[i]);
  end

  assign match = &hit;

endmodule
`default_nettype wire

/* verilog/rtc_time_step.sv */
// Next-second value of every time and calendar byte
`timescale 1ns/100ps
`default_nettype none
module rtc_time_step (
  // Format
  input wire logic dm,
  input wire logic h24,
  // Current bytes
  input wire logic [7:0] cur_sec,
  input wire logic [7:0] cur_min,
  input wire logic [7:0] cur_hour,
  input wire logic [7:0] cur_dow,
  input wire logic [7:0] cur_date,
  input wire logic [7:0] cur_mon,
  input wire logic [7:0] cur_year,
  input wire logic [7:0] cur_cent,
  // Advanced bytes
  output logic [7:0] nxt_sec,
  output logic [7:0] nxt_min,
  output logic [7:0] nxt_hour,
  output logic [7:0] nxt_dow,
  output logic [7:0] nxt_date,
  output logic [7:0] nxt_mon,
  output logic [7:0] nxt_year,
  output logic [7:0] nxt_cent
);
  import rtc_pkg::*;

  logic [7:0] sb, mb, hb, wb, db, ob, yb, cb, dim, hour_enc;
  logic pm, c_min, c_hour, c_day, c_mon, c_year, c_cent;

  always_comb begin
    // Work in binary, re-encode at the end
    sb = to_bin({1'b0, cur_sec[6:0]}, dm);
    mb = to_bin({1'b0, cur_min[6:0]}, dm);
    hb = to_bin({1'b0, cur_hour[6:0]}, dm);
    wb = cur_dow;
    db = to_bin(cur_date, dm);
    ob = to_bin(cur_mon, dm);
    yb = to_bin(cur_year, dm);
    cb = to_bin(cur_cent, dm);
    pm = cur_hour[7];
    c_day = 1'b0;
    c_min = (sb >= MAX_SEC);
    sb = c_min ? BYTE_RST : sb + CAL_RST;
    c_hour = c_min && (mb >= MAX_SEC);
    if (c_min) begin
      mb = c_hour ? BYTE_RST : mb + CAL_RST;
    end
    if (c_hour) begin
      if (h24) begin
        c_day = (hb >= MAX_HOUR24);
        hb = c_day ? BYTE_RST : hb + CAL_RST;
      end else if (hb == HOUR12_LAST_AM) begin
        // 11 to 12 flips the half of day; midnight when PM ends
        hb = HOUR12_TOP;
        c_day = pm;
        pm = !pm;
      end else if (hb >= HOUR12_TOP) begin
        hb = CAL_RST;
      end else begin
        hb = hb + CAL_RST;
      end
    end
    // Days in month, leap every fourth year
    case (ob)
      8'h02: dim = (yb[1:0] == 2'b00) ? DAYS_29 : DAYS_28;
      8'h04, 8'h06, 8'h09, 8'h0B: dim = DAYS_30;
      default: dim = DAYS_31;
    endcase
    c_mon = c_day && (db >= dim);
    if (c_day) begin
      wb = (wb >= MAX_DOW) ? CAL_RST : wb + CAL_RST;
      db = c_mon ? CAL_RST : db + CAL_RST;
    end
    c_year = c_mon && (ob >= MAX_MON);
    if (c_mon) begin
      ob = c_year ? CAL_RST : ob + CAL_RST;
    end
    c_cent = c_year && (yb >= MAX_YEAR);
    if (c_year) begin
      yb = c_cent ? BYTE_RST : yb + CAL_RST;
    end
    if (c_cent) begin
      cb = (cb >= MAX_YEAR) ? BYTE_RST : cb + CAL_RST;
    end
    hour_enc = to_enc(hb, dm);
    nxt_sec = to_enc(sb, dm);
    nxt_min = to_enc(mb, dm);
    nxt_hour = h24 ? hour_enc : {pm, hour_enc[6:0]};
    nxt_dow = wb;
    nxt_date = to_enc(db, dm);
    nxt_mon = to_enc(ob, dm);
    nxt_year = to_enc(yb, dm);
    nxt_cent = to_enc(cb, dm);
  end

endmodule
`default_nettype wire

/* verif/rtc_core_props.sv */
// Port-level checks of the real-time clock core
`timescale 1ns/100ps
`default_nettype none
module rtc_core_props (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Timebase and supply
  input wire logic osc_tick,
  input wire logic supply_ok,
  input wire logic battery_ok,
  // Host bus
  input wire logic host_cs,
  input wire logic host_ale,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_ad_in,
  input wire logic [7:0] host_ad_out,
  input wire logic host_ad_oe,
  // Interrupt and status
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  input wire logic host_access_ok
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_oe_needs_access: assert property (host_ad_oe |->
    host_cs && host_rd && host_access_ok)
    else $error("data bus driven outside a read");
  a_oe_on_read: assert property (host_cs && host_rd && host_access_ok
    |-> host_ad_oe) else $error("read not answered");
  a_irq_line_low: assert property (irq_n_oe |-> !irq_n_out)
    else $error("interrupt line not pulled low");
  a_access_needs_supply: assert property (host_access_ok
    |-> $past(supply_ok)) else $error("access open without supply");
  a_read_data_hold: assert property (!$stable(host_ad_out)
    |-> $past(host_cs && host_rd && host_access_ok))
    else $error("read data changed without a read");
  a_irq_request_holds: assert property (irq_n_oe && !host_rd &&
    !host_wr |=> irq_n_oe) else $error("interrupt dropped unread");
  a_irq_from_update: assert property ($rose(irq_n_oe) |->
    $past(osc_tick, 2) || $past(host_wr))
    else $error("interrupt without update or write");
  a_power_up_access: assert property ($rose(rst_n) && supply_ok
    |-> ##2 host_access_ok) else $error("stopped clock not opened");

  c_read: cover property (host_cs && host_rd && host_access_ok);
  c_irq: cover property ($rose(irq_n_oe));
  c_lock: cover property ($fell(host_access_ok));
endmodule
`default_nettype wire

/* verif/rtc_host_model.sv */
// Host processor on the multiplexed address/data bus
`timescale 1ns/100ps
`default_nettype none
module rtc_host_model (
  // Clock
  input wire logic clock,
  // Bus drive
  output var logic cs,
  output var logic ale,
  output var logic rd,
  output var logic wr,
  output var logic [7:0] ad,
  // Bus sense
  input wire logic [7:0] ad_bus
);
  initial begin
    cs = 1'b0;
    ale = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    ad = 8'h00;
  end

  task automatic addr_phase(input logic [6:0] a);
    @(negedge clock);
    cs = 1'b1;
    ale = 1'b1;
    ad = {1'b0, a};
  endtask

  // Released bus shows a changing pattern, not the last value
  task automatic release_bus();
    @(negedge clock);
    cs = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    ad = ~ad;
  endtask

  task automatic write_byte(input logic [6:0] a, input logic [7:0] d);
    addr_phase(a);
    @(negedge clock);
    ale = 1'b0;
    wr = 1'b1;
    ad = d;
    release_bus();
  endtask

  task automatic read_byte(input logic [6:0] a, output logic [7:0] d);
    addr_phase(a);
    @(negedge clock);
    ale = 1'b0;
    rd = 1'b1;
    @(posedge clock);
    @(posedge clock);
    d = ad_bus;
    release_bus();
  endtask
endmodule
`default_nettype wire

/* verif/tb_rtc_time_calendar_alarm_core.sv */
// Testbench of the real-time clock core
`timescale 1ns/100ps
`default_nettype none
module tb_rtc_time_calendar_alarm_core;
  import rtc_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic osc_tick = 1'b0;
  logic supply_ok = 1'b1;
  logic battery_ok = 1'b1;
  logic host_cs, host_ale, host_rd, host_wr, host_ad_oe;
  logic irq_n_out, irq_n_oe, host_access_ok;
  logic [7:0] host_ad_in, host_ad_out, hm_ad;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  // Byte order: sec, sec alarm, min, min alarm, hour, hour alarm, day,
  // date, month, year
  logic [7:0] set1 [10] = '{8'hD9, 8'hC0, 8'h59, 8'hC0, 8'h23, 8'hC0,
    8'h07, 8'h28, 8'h02, 8'h00};
  logic [7:0] exp1 [10] = '{8'h00, 8'hC0, 8'h00, 8'hC0, 8'h00, 8'hC0,
    8'h01, 8'h29, 8'h02, 8'h00};
  logic [7:0] set2 [10] = '{8'h59, 8'h00, 8'h59, 8'h00, 8'h91, 8'h12,
    8'h01, 8'h30, 8'h04, 8'h00};
  logic [7:0] exp2 [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h12, 8'h12,
    8'h02, 8'h01, 8'h05, 8'h00};

  always #4 clock = ~clock;

  rtc_core #(.REC_MS(1)) i_rtc_core (.clock(clock), .rst_n(rst_n),
    .osc_tick(osc_tick), .supply_ok(supply_ok), .battery_ok(battery_ok),
    .host_cs(host_cs), .host_ale(host_ale), .host_rd(host_rd),
    .host_wr(host_wr), .host_ad_in(host_ad_in), .host_ad_out(host_ad_out),
    .host_ad_oe(host_ad_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
    .host_access_ok(host_access_ok));

  rtc_host_model i_rtc_host_model (.clock(clock), .cs(host_cs),
    .ale(host_ale),
    .rd(host_rd), .wr(host_wr), .ad(hm_ad), .ad_bus(host_ad_in));

  assign host_ad_in = host_ad_oe ? host_ad_out : hm_ad;

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      $display("wrong value run length expected end seen timeout");
      results();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_rtc_host_model.write_byte(a, d);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp,
                        input logic [7:0] mask);
    logic [7:0] v;
    i_rtc_host_model.read_byte(a, v);
    chk($sformatf("byte %h", a), exp, v & mask);
  endtask

  task automatic wait_irq(input int limit);
    int n;
    n = 0;
    while (irq_n_oe !== 1'b1 && n < limit) begin
      @(negedge clock);
      n++;
    end
    chk("interrupt request", 8'h01, {7'h00, irq_n_oe});
  endtask

  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    chk("access after power-up", 8'h01, {7'h00, host_access_ok});
    rd_chk(ADDR_A, 8'h20, 8'hFF);
    wr(7'h0E, 8'h5A);
    wr(7'h7F, 8'hA5);
    wr(ADDR_CENT, 8'h19);
    rd_chk(7'h0E, 8'h5A, 8'hFF);
    rd_chk(7'h7F, 8'hA5, 8'hFF);
    rd_chk(ADDR_CENT, 8'h19, 8'hFF);
    wr(ADDR_C, 8'hFF);
    wr(ADDR_D, 8'h00);
    wr(ADDR_A, 8'hA0);
    rd_chk(ADDR_C, 8'h00, 8'hFF);
    rd_chk(ADDR_D, 8'h80, 8'hFF);
    rd_chk(ADDR_A, 8'h20, 8'hFF);
    wr(ADDR_B, 8'h82);
    for (int i = 0; i < 10; i++) wr(7'(i), set1[i]);
    rd_chk(ADDR_SEC, 8'h59, 8'hFF);
    wr(ADDR_B, 8'h22);
    osc_tick = 1'b1;
    wait_irq(20000);
    for (int i = 0; i < 10; i++) rd_chk(7'(i), exp1[i], 8'hFF);
    rd_chk(ADDR_C, 8'h20, 8'h20);
    chk("interrupt after flag read", 8'h00, {7'h00, irq_n_oe});
    wr(ADDR_B, 8'h80);
    for (int i = 0; i < 10; i++) wr(7'(i), set2[i]);
    wr(ADDR_B, 8'h20);
    wait_irq(40000);
    for (int i = 0; i < 10; i++) rd_chk(7'(i), exp2[i], 8'hFF);
    @(negedge clock);
    supply_ok = 1'b0;
    repeat (3) @(negedge clock);
    chk("access below threshold", 8'h00, {7'h00, host_access_ok});
    supply_ok = 1'b1;
    repeat (100) @(negedge clock);
    chk("access in recovery", 8'h00, {7'h00, host_access_ok});
    results();
  end
endmodule
`default_nettype wire

bind rtc_core rtc_core_props i_rtc_core_props (.clock(clock), .rst_n(rst_n),
  .osc_tick(osc_tick), .supply_ok(supply_ok), .battery_ok(battery_ok),
  .host_cs(host_cs), .host_ale(host_ale), .host_rd(host_rd),
  .host_wr(host_wr), .host_ad_in(host_ad_in), .host_ad_out(host_ad_out),
  .host_ad_oe(host_ad_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
  .host_access_ok(host_access_ok));
